// file: design/uctw_pkg.sv
`default_nettype none
package uctw_pkg;
	// register byte offsets on the avalon port
	localparam logic [7:0] UCTW_OFS_COMMAND = 8'h00;
	localparam logic [7:0] UCTW_OFS_MODE = 8'h04;
	localparam logic [7:0] UCTW_OFS_DIVISOR = 8'h08;
	localparam logic [7:0] UCTW_OFS_TXDATA = 8'h0C;
	localparam logic [7:0] UCTW_OFS_STATUS = 8'h10;
	localparam logic [7:0] UCTW_OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] UCTW_OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] UCTW_OFS_WP_MODE = 8'h1C;
	localparam logic [7:0] UCTW_OFS_WPSR = 8'hE8;
	// command register fields
	localparam int UCTW_CMD_CLR_STATUS_BIT = 8;
	// mode register fields
	localparam int UCTW_MODE_NET_BIT = 0;
	localparam int UCTW_MODE_ABORT_BIT = 1;
	localparam int UCTW_MODE_TEST_LSB = 14;
	localparam int UCTW_MODE_TEST_MSB = 15;
	localparam logic [31:0] UCTW_MODE_RESET = 32'h0000_0000;
	// write protect mode enable bit
	localparam int UCTW_WP_EN_BIT = 0;
	// status / irq layout
	localparam int UCTW_ST_TX_DONE = 0;
	localparam int UCTW_ST_COLL = 1;
	localparam int UCTW_ST_EARLY = 2;
	localparam int UCTW_ST_HOLD_FREE = 4;
	localparam int UCTW_FLAG_W = 3;
	// protection status fields
	localparam int UCTW_WPSR_SEEN_BIT = 0;
	localparam int UCTW_WPSR_SRC_LSB = 8;
	localparam int UCTW_WPSR_SRC_MSB = 23;
	// divisor reset: bit period in clock cycles
	localparam logic [15:0] UCTW_DIV_RESET = 16'h0010;
	localparam logic [2:0] UCTW_LAST_BIT = 3'h7;

	// test mode encodings
	typedef enum logic [1:0] {
		UCTW_TM_NORMAL = 2'h0,
		UCTW_TM_ECHO = 2'h1,
		UCTW_TM_LOCAL = 2'h2,
		UCTW_TM_REMOTE = 2'h3
	} uctw_test_e;

	// transmitter states, one-hot
	typedef enum logic [3:0] {
		UCTW_TX_IDLE = 4'h1,
		UCTW_TX_START = 4'h2,
		UCTW_TX_DATA = 4'h4,
		UCTW_TX_STOP = 4'h8
	} uctw_tx_e;

	// avalon-mm slave request
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} uctw_av_req_s;

	// avalon-mm slave answer
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} uctw_av_rsp_s;

	// serial pins
	typedef struct packed {
		logic rxd;
		logic collision;
	} uctw_line_in_s;
endpackage : uctw_pkg
`default_nettype wire

// file: design/uctw_top.sv
// Functional notes
// - network mode aborts frame on collision
// - early end first pulses end-of-frame trigger
// - hold transmit-ready low after collision abort
// - abort sets done, collision, early-end flags
// - status-reset clears collision and early-end flags (done kept), releases transmit-ready
// - three selectable test modes besides normal
// - loopback reroutes paths, pins optionally disconnected
// - normal: rx pin to receiver, tx to pin
// - violation source holds blocked write offset
// - violation bit set since last read, read-clears
// - source updates only on protected register write
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module uctw_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire uctw_pkg::uctw_av_req_s av_req,
	output uctw_pkg::uctw_av_rsp_s av_rsp,
	input wire uctw_pkg::uctw_line_in_s line_in,
	output logic txd_pin,
	output logic rx_to_receiver,
	output logic tx_holding_free,
	output logic frame_end_trigger,
	output logic irq
);
	import uctw_pkg::*;

	// whole state of the block
	typedef struct packed {
		logic resp;                    // second cycle of a bus access
		logic [31:0] rdata;            // registered read data
		logic [31:0] mode;             // network and test mode
		logic [15:0] divisor;          // bit period in clocks
		logic [UCTW_FLAG_W-1:0] flags; // sticky event flags
		logic [UCTW_FLAG_W-1:0] irq_en;
		logic wp_en;                   // write protection on
		logic wp_seen;                 // violation since last read
		logic [15:0] wp_src;           // offset of blocked write
		logic [7:0] hold;              // holding register
		logic hold_full;
		logic [7:0] shift;             // shift register
		logic [2:0] bit_cnt;
		logic [15:0] baud_cnt;
		uctw_tx_e tx_st;
		logic tx_line;                 // transmitter output level
		logic trig;                    // end-of-frame trigger pulse
	} uctw_state_s;

	uctw_state_s s_q;
	uctw_state_s s_d;

	logic req;           // any bus request present
	logic acc_wr;        // write completes this edge
	logic acc_rd;        // read completes this edge
	logic prot_hit;      // target is a protected register
	logic wp_violation;  // blocked write this edge
	logic wr_ok;         // permitted write
	logic blocked;       // transmit-ready held down
	logic abort_ev;      // collision abort this edge
	logic baud_tick;     // one bit period elapsed
	logic frame_end;     // normal end of character
	logic [UCTW_FLAG_W-1:0] flag_set;
	logic [UCTW_FLAG_W-1:0] flag_clr;
	uctw_test_e test_mode;
	logic [31:0] status_word;
	logic [31:0] rmux;

	// bus decode helpers
	assign req = av_req.read | av_req.write;
	assign acc_wr = av_req.write & s_q.resp;
	assign acc_rd = av_req.read & s_q.resp;
	assign prot_hit = (av_req.address == UCTW_OFS_MODE) | (av_req.address == UCTW_OFS_DIVISOR);
	assign wp_violation = acc_wr & prot_hit & s_q.wp_en;
	assign wr_ok = acc_wr & ~wp_violation;
	assign test_mode = uctw_test_e'(s_q.mode[UCTW_MODE_TEST_MSB:UCTW_MODE_TEST_LSB]);

	// collision or early-end flag keeps the dma request low
	assign blocked = s_q.flags[UCTW_ST_COLL] | s_q.flags[UCTW_ST_EARLY];
	// abort only in network mode with abort enabled, during a frame
	assign abort_ev = s_q.mode[UCTW_MODE_NET_BIT] & s_q.mode[UCTW_MODE_ABORT_BIT]
		& line_in.collision & (s_q.tx_st != UCTW_TX_IDLE);
	assign baud_tick = (s_q.baud_cnt == 16'h0000);
	assign frame_end = (s_q.tx_st == UCTW_TX_STOP) & baud_tick & ~abort_ev;

	// live status word, flags in low bits
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[UCTW_FLAG_W-1:0] = s_q.flags;
		status_word[UCTW_ST_HOLD_FREE] = tx_holding_free;
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rmux = 32'h0000_0000;
		if (av_req.address == UCTW_OFS_MODE) begin
			rmux = s_q.mode;
		end else if (av_req.address == UCTW_OFS_DIVISOR) begin
			rmux[15:0] = s_q.divisor;
		end else if (av_req.address == UCTW_OFS_STATUS) begin
			rmux = status_word;
		end else if (av_req.address == UCTW_OFS_IRQ_EN) begin
			rmux[UCTW_FLAG_W-1:0] = s_q.irq_en;
		end else if (av_req.address == UCTW_OFS_WP_MODE) begin
			rmux[UCTW_WP_EN_BIT] = s_q.wp_en;
		end else if (av_req.address == UCTW_OFS_WPSR) begin
			rmux[UCTW_WPSR_SEEN_BIT] = s_q.wp_seen;
			rmux[UCTW_WPSR_SRC_MSB:UCTW_WPSR_SRC_LSB] = s_q.wp_src;
		end else begin
			rmux = 32'h0000_0000;
		end
	end

	// flag set and clear terms, set wins
	always_comb begin
		flag_set = '0;
		flag_clr = '0;
		if (abort_ev) begin
			flag_set = '1;
		end
		if (frame_end & s_q.mode[UCTW_MODE_NET_BIT]) begin
			flag_set[UCTW_ST_TX_DONE] = 1'b1;
		end
		if (wr_ok & (av_req.address == UCTW_OFS_COMMAND) & av_req.writedata[UCTW_CMD_CLR_STATUS_BIT]) begin
			flag_clr[UCTW_ST_COLL] = 1'b1;
			flag_clr[UCTW_ST_EARLY] = 1'b1;
		end
		if (wr_ok & (av_req.address == UCTW_OFS_IRQ_CLR)) begin
			flag_clr = flag_clr | av_req.writedata[UCTW_FLAG_W-1:0];
		end
	end

	// next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.trig = 1'b0;
		// bus handshake: first cycle waits, second completes
		s_d.resp = req & ~s_q.resp;
		if (req & ~s_q.resp) begin
			s_d.rdata = rmux;
		end
		// permitted register writes
		if (wr_ok) begin
			if (av_req.address == UCTW_OFS_MODE) begin
				s_d.mode = av_req.writedata;
			end else if (av_req.address == UCTW_OFS_DIVISOR) begin
				s_d.divisor = av_req.writedata[15:0];
			end else if (av_req.address == UCTW_OFS_IRQ_EN) begin
				s_d.irq_en = av_req.writedata[UCTW_FLAG_W-1:0];
			end else if (av_req.address == UCTW_OFS_WP_MODE) begin
				s_d.wp_en = av_req.writedata[UCTW_WP_EN_BIT];
			end else if (av_req.address == UCTW_OFS_TXDATA) begin
				// ignored while holding is full or transmit-ready is held down
				if (~s_q.hold_full & ~blocked) begin
					s_d.hold = av_req.writedata[7:0];
					s_d.hold_full = 1'b1;
				end
			end else begin
				s_d.mode = s_q.mode;
			end
		end
		// protection status: read clears, a new violation wins
		if (acc_rd & (av_req.address == UCTW_OFS_WPSR)) begin
			s_d.wp_seen = 1'b0;
		end
		if (wp_violation) begin
			s_d.wp_seen = 1'b1;
			s_d.wp_src = {8'h00, av_req.address};
		end
		// sticky flags
		s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
		// bit period counter
		if (baud_tick | (s_q.tx_st == UCTW_TX_IDLE)) begin
			s_d.baud_cnt = s_q.divisor - 16'h0001;
		end else begin
			s_d.baud_cnt = s_q.baud_cnt - 16'h0001;
		end
		// transmitter sequence
		case (s_q.tx_st)
			UCTW_TX_IDLE: begin
				s_d.tx_line = 1'b1;
				if (s_q.hold_full) begin
					s_d.shift = s_q.hold;
					s_d.hold_full = 1'b0;
					s_d.tx_line = 1'b0;
					s_d.tx_st = UCTW_TX_START;
				end
			end
			UCTW_TX_START: begin
				if (baud_tick) begin
					s_d.tx_line = s_q.shift[0];
					s_d.bit_cnt = 3'h0;
					s_d.tx_st = UCTW_TX_DATA;
				end
			end
			UCTW_TX_DATA: begin
				if (baud_tick) begin
					if (s_q.bit_cnt == UCTW_LAST_BIT) begin
						s_d.tx_line = 1'b1;
						s_d.tx_st = UCTW_TX_STOP;
					end else begin
						s_d.shift = {1'b0, s_q.shift[7:1]};
						s_d.tx_line = s_q.shift[1];
						s_d.bit_cnt = s_q.bit_cnt + 3'h1;
					end
				end
			end
			UCTW_TX_STOP: begin
				if (baud_tick) begin
					s_d.trig = 1'b1;
					s_d.tx_st = UCTW_TX_IDLE;
				end
			end
			default: begin
				s_d.tx_st = UCTW_TX_IDLE;
			end
		endcase
		// collision abort overrides the sequence
		if (abort_ev) begin
			s_d.tx_st = UCTW_TX_IDLE;
			s_d.tx_line = 1'b1;
			s_d.trig = 1'b1;
			// pending data dropped; software reprograms the dma channel
			s_d.hold_full = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.mode <= UCTW_MODE_RESET;
			s_q.divisor <= UCTW_DIV_RESET;
			s_q.tx_st <= UCTW_TX_IDLE;
			s_q.tx_line <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// pin routing per test mode
	always_comb begin
		case (test_mode)
			UCTW_TM_NORMAL: begin
				rx_to_receiver = line_in.rxd;
				txd_pin = s_q.tx_line;
			end
			UCTW_TM_ECHO: begin
				// receiver still listens, pin echoes input
				rx_to_receiver = line_in.rxd;
				txd_pin = line_in.rxd;
			end
			UCTW_TM_LOCAL: begin
				// internal loop, pins disconnected
				rx_to_receiver = s_q.tx_line;
				txd_pin = 1'b1;
			end
			UCTW_TM_REMOTE: begin
				// external loop, receiver idle
				rx_to_receiver = 1'b1;
				txd_pin = line_in.rxd;
			end
			default: begin
				rx_to_receiver = line_in.rxd;
				txd_pin = s_q.tx_line;
			end
		endcase
	end

	// outputs
	assign tx_holding_free = ~s_q.hold_full & ~blocked;
	assign frame_end_trigger = s_q.trig;
	assign irq = |(s_q.flags & s_q.irq_en);
	assign av_rsp.waitrequest = req & ~s_q.resp;
	assign av_rsp.readdata = s_q.rdata;

	// checks
	chk_abort_to_idle: assert property (@(posedge clk) disable iff (sys_rst)
		abort_ev |=> (s_q.tx_st == UCTW_TX_IDLE) && s_q.tx_line)
		else $error("abort did not end the frame");

	chk_abort_trigger: assert property (@(posedge clk) disable iff (sys_rst)
		abort_ev |=> frame_end_trigger ##1 !frame_end_trigger)
		else $error("no single end-of-frame pulse on abort");

	chk_ready_held_low: assert property (@(posedge clk) disable iff (sys_rst)
		abort_ev |=> !tx_holding_free throughout (s_q.flags[UCTW_ST_COLL] [*1]))
		else $error("transmit-ready rose after abort");

	chk_abort_flags: assert property (@(posedge clk) disable iff (sys_rst)
		abort_ev |=> s_q.flags[UCTW_ST_TX_DONE] && s_q.flags[UCTW_ST_COLL] && s_q.flags[UCTW_ST_EARLY])
		else $error("abort flags not set");

	chk_status_release: assert property (@(posedge clk) disable iff (sys_rst)
		(blocked && !abort_ev && (flag_clr[UCTW_ST_COLL] && flag_clr[UCTW_ST_EARLY]))
		|=> !blocked ##0 (tx_holding_free == !s_q.hold_full))
		else $error("status reset did not release transmit-ready");

	chk_ready_vs_flags: assert property (@(posedge clk) disable iff (sys_rst)
		blocked |-> !tx_holding_free)
		else $error("transmit-ready high with collision flag");

	chk_normal_route: assert property (@(posedge clk) disable iff (sys_rst)
		(test_mode == UCTW_TM_NORMAL) |-> (txd_pin == s_q.tx_line) && (rx_to_receiver == line_in.rxd))
		else $error("normal routing wrong");

	chk_local_loop: assert property (@(posedge clk) disable iff (sys_rst)
		(test_mode == UCTW_TM_LOCAL) |-> txd_pin && (rx_to_receiver == s_q.tx_line))
		else $error("local loopback routing wrong");

	chk_wp_source: assert property (@(posedge clk) disable iff (sys_rst)
		wp_violation |=> s_q.wp_seen && (s_q.wp_src == {8'h00, $past(av_req.address)}))
		else $error("violation source not captured");

	chk_wp_src_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!wp_violation |=> $stable(s_q.wp_src))
		else $error("violation source changed without violation");

	chk_wp_readclr: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_rd && (av_req.address == UCTW_OFS_WPSR) && !wp_violation) |=> !s_q.wp_seen)
		else $error("violation flag not cleared by read");

	chk_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
		(req && av_rsp.waitrequest) ##1 req |-> !av_rsp.waitrequest)
		else $error("bus answer later than one cycle");

	chk_echo_route: assert property (@(posedge clk) disable iff (sys_rst)
		(test_mode == UCTW_TM_ECHO) |-> (txd_pin == line_in.rxd) && (rx_to_receiver == line_in.rxd))
		else $error("echo routing wrong");

	chk_remote_loop: assert property (@(posedge clk) disable iff (sys_rst)
		(test_mode == UCTW_TM_REMOTE) |-> (txd_pin == line_in.rxd) && rx_to_receiver)
		else $error("remote loopback routing wrong");

	chk_blocked_write: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_ok && (av_req.address == UCTW_OFS_TXDATA) && blocked) |=> $stable(s_q.hold) && !s_q.hold_full)
		else $error("data accepted while transmit-ready held down");

	chk_wp_blocks: assert property (@(posedge clk) disable iff (sys_rst)
		wp_violation |=> $stable(s_q.mode) && $stable(s_q.divisor))
		else $error("protected register changed by blocked write");
endmodule : uctw_top
`default_nettype wire

// file: dv/uctw_net_node.sv
`timescale 1ns/10ps
`default_nettype none
module uctw_net_node (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic txd_pin,
	input wire logic rx_level,
	input wire logic arm,
	output uctw_pkg::uctw_line_in_s line_in
);
	import uctw_pkg::*;
	logic prev_q; // last seen transmit level
	logic busy_q; // a frame start was seen while armed
	logic [3:0] cnt_q; // cycles since the start bit began
	// when armed, a remote node reports a collision a few cycles into the frame
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= 1'h1;
			busy_q <= 1'h0;
			cnt_q <= 4'h0;
		end else begin
			prev_q <= txd_pin;
			if (arm && prev_q && !txd_pin && !busy_q) begin
				busy_q <= 1'h1;
				cnt_q <= 4'h0;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 4'h1;
				// notification lasts two cycles, then the node goes quiet
				if (cnt_q == 4'hA) begin
					busy_q <= 1'h0;
				end
			end
		end
	end
	// receive line follows the bench level; collision is a short level pulse
	always_comb begin
		line_in.rxd = rx_level;
		line_in.collision = busy_q && (cnt_q >= 4'h8) && (cnt_q <= 4'h9);
	end
endmodule : uctw_net_node
`default_nettype wire

// file: dv/uctw_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uctw_top_tb;
	import uctw_pkg::*;
	logic clk = 1'h0; // 40 MHz clock
	logic sys_rst = 1'h1; // held for 20 cycles
	uctw_av_req_s av_req = '0; // register bus request
	uctw_av_rsp_s av_rsp;
	uctw_line_in_s line_in;
	logic txd_pin, rx_to_receiver, tx_holding_free, frame_end_trigger, irq;
	logic rx_level = 1'h1; // receive line level given to the node
	logic arm = 1'h0; // node will report a collision on the next frame
	int miscompares = 0;
	int num_checks = 0;
	logic [31:0] rd; // last read data
	// per test mode with rxd low: expected pin and receiver levels
	localparam logic [3:0] EXP_TXD = 4'h5;
	localparam logic [3:0] EXP_RX = 4'hC;
	always #12.5 clk = ~clk;
	uctw_top i_dut (.clk(clk), .sys_rst(sys_rst), .av_req(av_req), .av_rsp(av_rsp), .line_in(line_in),
		.txd_pin(txd_pin), .rx_to_receiver(rx_to_receiver), .tx_holding_free(tx_holding_free),
		.frame_end_trigger(frame_end_trigger), .irq(irq));
	uctw_net_node i_node (.clk(clk), .sys_rst(sys_rst), .txd_pin(txd_pin), .rx_level(rx_level), .arm(arm),
		.line_in(line_in));
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// verdict and end of run
	task automatic summarize;
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	// one bus access, held until waitrequest is low at a rising edge
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] data, output logic [31:0] q);
		// let an edge pass so a release and a new request never share a time step
		@(posedge clk);
		av_req <= '{read: !wr, write: wr, address: addr, writedata: data};
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (av_rsp.waitrequest !== 1'h0);
		// read data taken at the completing edge, request released there
		q = av_rsp.readdata;
		av_req <= '0;
	endtask : access
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		access(1'h1, addr, data, rd);
	endtask : wr
	task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		access(1'h0, addr, 32'h0, rd);
		check(what, rd, exp);
	endtask : rdchk
	// wait for the end-of-frame pulse under a bound
	task automatic wait_trig;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (frame_end_trigger !== 1'h1 && n < 400);
		check("frame end pulse", {31'h0, frame_end_trigger}, 32'h1);
		@(posedge clk);
		// the pulse stands for one cycle only
		check("frame end pulse width", {31'h0, frame_end_trigger}, 32'h0);
		if (n >= 400) begin
			summarize();
		end
	endtask : wait_trig
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		rdchk("wpsr reset", UCTW_OFS_WPSR, 32'h0000_0000);
		rdchk("status reset", UCTW_OFS_STATUS, 32'h0000_0010);
		@(posedge clk);
		check("rx path normal", {31'h0, rx_to_receiver}, 32'h1);
		check("txd pin normal", {31'h0, txd_pin}, 32'h1);
		rx_level <= 1'h0;
		// every test mode, rxd held low
		for (int m = 0; m < 4; m++) begin
			wr(UCTW_OFS_MODE, {16'h0, m[1:0], 14'h0});
			@(posedge clk);
			check("txd pin route", {31'h0, txd_pin}, {31'h0, EXP_TXD[m]});
			check("rx path route", {31'h0, rx_to_receiver}, {31'h0, EXP_RX[m]});
		end
		rx_level <= 1'h1;
		// collision during a network frame
		wr(UCTW_OFS_MODE, 32'h0000_0003);
		wr(UCTW_OFS_IRQ_EN, 32'h0000_0007);
		arm <= 1'h1;
		wr(UCTW_OFS_TXDATA, 32'h0000_005A);
		wait_trig();
		check("holding free after abort", {31'h0, tx_holding_free}, 32'h0);
		check("txd after abort", {31'h0, txd_pin}, 32'h1);
		check("irq after abort", {31'h0, irq}, 32'h1);
		@(posedge clk);
		arm <= 1'h0;
		wr(UCTW_OFS_TXDATA, 32'h0000_00FF);
		rdchk("status after abort", UCTW_OFS_STATUS, 32'h0000_0007);
		@(posedge clk);
		check("txd stays idle", {31'h0, txd_pin}, 32'h1);
		wr(UCTW_OFS_COMMAND, 32'h0000_0100);
		@(posedge clk);
		check("holding free released", {31'h0, tx_holding_free}, 32'h1);
		rdchk("status after clear", UCTW_OFS_STATUS, 32'h0000_0011);
		wr(UCTW_OFS_IRQ_CLR, 32'h0000_0001);
		@(posedge clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		// reprogrammed transfer, done flag masked
		wr(UCTW_OFS_IRQ_EN, 32'h0000_0000);
		wr(UCTW_OFS_TXDATA, 32'h0000_00A5);
		wait_trig();
		check("irq masked", {31'h0, irq}, 32'h0);
		rdchk("status normal end", UCTW_OFS_STATUS, 32'h0000_0011);
		wr(UCTW_OFS_IRQ_EN, 32'h0000_0001);
		@(posedge clk);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		wr(UCTW_OFS_IRQ_CLR, 32'h0000_0007);
		@(posedge clk);
		check("irq after clear", {31'h0, irq}, 32'h0);
		// write protection
		wr(UCTW_OFS_WP_MODE, 32'h0000_0001);
		wr(UCTW_OFS_MODE, 32'h0000_C000);
		rdchk("mode kept", UCTW_OFS_MODE, 32'h0000_0003);
		rdchk("wpsr mode", UCTW_OFS_WPSR, 32'h0000_0401);
		rdchk("wpsr read clear", UCTW_OFS_WPSR, 32'h0000_0400);
		wr(UCTW_OFS_IRQ_EN, 32'h0000_0000);
		rdchk("wpsr unprotected", UCTW_OFS_WPSR, 32'h0000_0400);
		wr(UCTW_OFS_DIVISOR, 32'h0000_0008);
		rdchk("wpsr divisor", UCTW_OFS_WPSR, 32'h0000_0801);
		rdchk("divisor kept", UCTW_OFS_DIVISOR, 32'h0000_0010);
		rdchk("unmapped read", 8'h40, 32'h0000_0000);
		summarize();
	end
	// watchdog well past the expected run length
	initial begin
		#500000;
		miscompares++;
		summarize();
	end
endmodule : uctw_top_tb
`default_nettype wire
